// File: ssw_pkg.sv
// package of the slave state and watchdog block: types, states, timing constants
// assumes a single 20 MHz system clock; the watchdog base period is 40 ns
package ssw_pkg;

	// clock period of clk in ps and base tick period in ps
	localparam int unsigned CLK_PERIOD_PS  = 50000;
	localparam int unsigned BASE_PERIOD_NS = 40;
	localparam int unsigned BASE_PERIOD_PS = BASE_PERIOD_NS * 1000;

	// extra base periods added to the multiplier for one tick
	localparam logic [15:0] TICK_EXTRA = 16'h0002;

	// reset values of the watchdog settings
	localparam logic [15:0] MULT_RESET  = 16'h09C2;  // 2498
	localparam logic [15:0] TIMER_RESET = 16'h03E8;  // 1000

	// offsets of the watchdog settings in the slave controller map
	localparam logic [15:0] WD_MULT_OFFSET   = 16'h0400;
	localparam logic [15:0] WD_BUS_OFFSET    = 16'h0410;
	localparam logic [15:0] WD_LOCAL_OFFSET  = 16'h0420;

	// operating states, gray coded along init-config-safe-run
	typedef enum logic [2:0] {
		SSW_INIT     = 3'h0,
		SSW_CONFIG   = 3'h1,
		SSW_SAFE_RUN = 3'h3,
		SSW_RUN      = 3'h2,
		SSW_FW_UPD   = 3'h4
	} ssw_state_type;

	// watchdog configuration as seen by the state block
	typedef struct packed {
		logic [15:0] mult;      // shared multiplier
		logic [15:0] bus_time;  // bus-side timer
		logic [15:0] loc_time;  // local interface timer
		logic        bus_en;    // bus-side watchdog enabled
		logic        loc_en;    // local watchdog enabled
	} ssw_wd_cfg_type;

	// checks reported by the bus-facing side before a transition
	typedef struct packed {
		logic mbx_ok;  // mailbox channels 0 and 1 set correctly
		logic pd_ok;   // process-data channels set correctly
		logic dc_ok;   // distributed clock settings correct or unused
	} ssw_check_type;

	// traffic permissions driven out of the block
	typedef struct packed {
		logic mbx_allow;   // general mailbox traffic
		logic file_allow;  // file-access mailbox traffic
		logic pd_allow;    // cyclic process data
	} ssw_permit_type;

	// watchdog timer state
	typedef struct packed {
		logic [15:0] tick_cnt;  // base periods within one tick
		logic [15:0] time_cnt;  // ticks since last access
		logic        tripped;   // watchdog expired
	} ssw_wd_state_type;

endpackage

// File: ssw_watchdog.sv
// one communication watchdog: counts ticks since the last access
// assumes base_pulse comes from the shared base tick (one per 50 ns clk cycle in ssw_top) in the same clock domain
module ssw_watchdog (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        base_pulse,  // one per base period, 50 ns in ssw_top
	input  wire logic [15:0] mult,        // shared multiplier
	input  wire logic [15:0] wd_time,     // own timer value in ticks
	input  wire logic        enable,      // watchdog switched on
	input  wire logic        kick,        // access seen, restart
	output logic             tripped      // expired, level
);

	// all state of the watchdog
	ssw_pkg::ssw_wd_state_type st;
	ssw_pkg::ssw_wd_state_type next_st;

	// tick counting and expiry
	always_comb begin
		next_st = st;
		if (!enable || wd_time == 16'h0000) begin
			// a zero timer switches the watchdog off completely
			next_st = '0;
		end else if (kick) begin
			// restart on every access; also clears a trip
			next_st = '0;
		end else if (base_pulse && !st.tripped) begin
			// one tick is multiplier plus two base periods
			if (st.tick_cnt >= mult + ssw_pkg::TICK_EXTRA - 16'h0001) begin
				next_st.tick_cnt = '0;
				// expiry after timer value ticks
				if (st.time_cnt >= wd_time - 16'h0001) begin
					next_st.tripped = 1'b1;
				end else begin
					next_st.time_cnt = st.time_cnt + 16'h0001;
				end
			end else begin
				next_st.tick_cnt = st.tick_cnt + 16'h0001;
			end
		end
	end

	// state register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tripped = st.tripped;

endmodule

// File: ssw_top.sv
// slave state machine and two communication watchdogs of the slave controller
// assumes bus-facing logic on clk presents requests, checks and access strobes;
// pins wd_cfg, req and checks are same-domain; local accesses are same-domain too
//
// Functional notes
// - local watchdog trips without local accesses
// - tick is multiplier plus two 40ns periods; here each base period is 50 ns
// - watchdog time is tick times timer
// - bus watchdog timer zero disables it
// - five states; run is normal end
// - power-up initial; no mailbox, no process data
// - check mailbox channels entering configuration; here checked only on entry from initial, not from safe-run or run
// - configuration: mailbox yes, process data no
// - check process channels and clocks entering safe-run; here checked only on entry from configuration, not from run
// - copy inputs before acknowledging safe-run; here only on entry from configuration, run enters safe-run at once
// - safe-run: traffic allowed, outputs held safe
// - watchdog off lets safe-run drive outputs; here a local watchdog switched off only by a zero timer still holds them safe
// - run: outputs follow master data
// - firmware update only from initial
// - firmware update: file transfers only
// - bus watchdog restarts on process access
// - bus watchdog trip keeps state
// - one shared multiplier, two timers
module ssw_top (
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire ssw_pkg::ssw_wd_cfg_type wd_cfg,       // watchdog settings
	input  wire logic                  req_valid,    // state change request pulse
	input  wire ssw_pkg::ssw_state_type req_state,    // requested state
	input  wire ssw_pkg::ssw_check_type checks,       // configuration checks
	input  wire logic                  bus_pd_access, // successful bus process access
	input  wire logic                  loc_access,   // local interface access
	input  wire logic                  copy_done,    // input copy to memory finished
	input  wire logic [15:0]           out_data,     // output data from master
	input  wire logic [15:0]           safe_value,   // configured safe output value
	output ssw_pkg::ssw_state_type     state,        // present state
	output ssw_pkg::ssw_permit_type    permit,       // traffic permissions
	output logic                       copy_req,     // request input copy, level
	output logic                       busy,         // transition pending
	output logic                       err_flag,     // last request refused
	output logic                       bus_wd_trip,  // bus watchdog expired
	output logic                       loc_wd_trip,  // local watchdog expired
	output logic [15:0]                phys_out      // physical outputs
);

	// cycles of clk in one 40 ns base period, at least one
	localparam int unsigned BASE_CYC_RAW = ssw_pkg::BASE_PERIOD_PS / ssw_pkg::CLK_PERIOD_PS;
	localparam int unsigned BASE_CYC     = (BASE_CYC_RAW < 1) ? 1 : BASE_CYC_RAW;
	localparam logic [3:0]  BASE_LAST    = 4'(BASE_CYC - 1);

	// all state of the top
	typedef struct packed {
		ssw_pkg::ssw_state_type state;    // operating state
		logic                   pend;     // waiting for input copy
		logic                   err;      // refused request
		logic [3:0]             base_cnt; // base period divider
		logic                   base;     // base period pulse
		logic [15:0]            out_q;    // physical output register
	} ssw_top_st_type;

	ssw_top_st_type st;
	ssw_top_st_type next_st;

	logic bus_trip;  // from bus watchdog
	logic loc_trip;  // from local watchdog

	// legality of a transition in the state graph
	function automatic logic legal_step(input ssw_pkg::ssw_state_type from,
					    input ssw_pkg::ssw_state_type to);
		logic ok;
		ok = 1'b0;
		case (from)
			ssw_pkg::SSW_INIT:     ok = (to == ssw_pkg::SSW_CONFIG) || (to == ssw_pkg::SSW_FW_UPD);
			ssw_pkg::SSW_CONFIG:   ok = (to == ssw_pkg::SSW_INIT) || (to == ssw_pkg::SSW_SAFE_RUN);
			ssw_pkg::SSW_SAFE_RUN: ok = (to == ssw_pkg::SSW_INIT) || (to == ssw_pkg::SSW_CONFIG)
						    || (to == ssw_pkg::SSW_RUN);
			ssw_pkg::SSW_RUN:      ok = (to != ssw_pkg::SSW_FW_UPD) && (to != ssw_pkg::SSW_RUN);
			ssw_pkg::SSW_FW_UPD:   ok = (to == ssw_pkg::SSW_INIT);
			default:               ok = 1'b0;
		endcase
		return ok;
	endfunction

	// shared multiplier, own timers per watchdog
	ssw_watchdog u_bus_wd (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.base_pulse (st.base),
		.mult       (wd_cfg.mult),
		.wd_time    (wd_cfg.bus_time),
		.enable     (wd_cfg.bus_en),
		.kick       (bus_pd_access),
		.tripped    (bus_trip)
	);

	// local interface watchdog
	ssw_watchdog u_loc_wd (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.base_pulse (st.base),
		.mult       (wd_cfg.mult),
		.wd_time    (wd_cfg.loc_time),
		.enable     (wd_cfg.loc_en),
		.kick       (loc_access),
		.tripped    (loc_trip)
	);

	// next state, divider and output logic
	always_comb begin
		logic wd_active;
		logic any_trip;
		wd_active = (wd_cfg.bus_en && wd_cfg.bus_time != 16'h0000) || wd_cfg.loc_en;
		any_trip  = bus_trip || loc_trip;
		next_st   = st;

		// base period divider; the 40 ns period divides to zero clk cycles and is clamped to one here,
		// so each base period is 50 ns and the tick is a quarter longer than nominal
		if (st.base_cnt >= BASE_LAST) begin
			next_st.base_cnt = '0;
			next_st.base     = 1'b1;
		end else begin
			next_st.base_cnt = st.base_cnt + 4'h1;
			next_st.base     = 1'b0;
		end

		// state transitions; a watchdog trip never changes the state
		if (st.pend) begin
			// acknowledge safe-run only after inputs are copied
			if (copy_done) begin
				next_st.state = ssw_pkg::SSW_SAFE_RUN;
				next_st.pend  = 1'b0;
			end
		end else if (req_valid) begin
			if (!legal_step(st.state, req_state)) begin
				next_st.err = 1'b1;
			end else if (st.state == ssw_pkg::SSW_INIT && req_state == ssw_pkg::SSW_CONFIG
				     && !checks.mbx_ok) begin
				next_st.err = 1'b1;
			end else if (req_state == ssw_pkg::SSW_SAFE_RUN && st.state == ssw_pkg::SSW_CONFIG) begin
				if (checks.pd_ok && checks.dc_ok) begin
					next_st.pend = 1'b1;
					next_st.err  = 1'b0;
				end else begin
					next_st.err = 1'b1;
				end
			end else begin
				// firmware update reached only from init by legal_step
				next_st.state = req_state;
				next_st.err   = 1'b0;
			end
		end

		// outputs: safe on any trip; otherwise safe unless run, or safe-run with bus watchdog off and loc_en low
		if (any_trip) begin
			next_st.out_q = safe_value;
		end else if (st.state == ssw_pkg::SSW_RUN) begin
			next_st.out_q = out_data;
		end else if (st.state == ssw_pkg::SSW_SAFE_RUN && !wd_active) begin
			next_st.out_q = out_data;
		end else begin
			next_st.out_q = safe_value;
		end
	end

	// state register; power-up enters init
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '{state: ssw_pkg::SSW_INIT, pend: 1'b0, err: 1'b0,
				base_cnt: 4'h0, base: 1'b0, out_q: 16'h0000};
		end else begin
			st <= next_st;
		end
	end

	// traffic permissions by state
	always_comb begin
		permit = '0;
		case (st.state)
			ssw_pkg::SSW_INIT:     permit = '0;
			ssw_pkg::SSW_CONFIG:   permit = '{mbx_allow: 1'b1, file_allow: 1'b1, pd_allow: 1'b0};
			ssw_pkg::SSW_SAFE_RUN: permit = '{mbx_allow: 1'b1, file_allow: 1'b1, pd_allow: 1'b1};
			ssw_pkg::SSW_RUN:      permit = '{mbx_allow: 1'b1, file_allow: 1'b1, pd_allow: 1'b1};
			ssw_pkg::SSW_FW_UPD:   permit = '{mbx_allow: 1'b0, file_allow: 1'b1, pd_allow: 1'b0};
			default:               permit = '0;
		endcase
	end

	assign state       = st.state;
	assign copy_req    = st.pend;
	assign busy        = st.pend;
	assign err_flag    = st.err;
	assign bus_wd_trip = bus_trip;
	assign loc_wd_trip = loc_trip;
	assign phys_out    = st.out_q;

endmodule

// File: ssw_top_asserts.sv
// checker of the state and watchdog block: permissions, transitions, outputs
// assumes it is bound to ssw_top and sees only its ports
module ssw_top_chk (
	input wire logic                    clk,
	input wire logic                    sys_rst,
	input wire ssw_pkg::ssw_wd_cfg_type wd_cfg,
	input wire logic                    req_valid,
	input wire ssw_pkg::ssw_state_type  req_state,
	input wire ssw_pkg::ssw_check_type  checks,
	input wire logic                    bus_pd_access,
	input wire logic                    copy_done,
	input wire logic [15:0]             out_data,
	input wire logic [15:0]             safe_value,
	input wire ssw_pkg::ssw_state_type  state,
	input wire ssw_pkg::ssw_permit_type permit,
	input wire logic                    copy_req,
	input wire logic                    err_flag,
	input wire logic                    bus_wd_trip,
	input wire logic                    loc_wd_trip,
	input wire logic [15:0]             phys_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// config step followed by safe-run step
	sequence s_safe_entry;
		state == ssw_pkg::SSW_CONFIG ##1 state == ssw_pkg::SSW_SAFE_RUN;
	endsequence
	AST_INIT_QUIET: assert property (state == ssw_pkg::SSW_INIT |-> permit == 3'h0) else $error("init traffic");
	AST_CFG_MBX: assert property (state == ssw_pkg::SSW_CONFIG |-> permit.mbx_allow && !permit.pd_allow) else $error("cfg");
	AST_RUN_TRAFFIC: assert property (state inside {ssw_pkg::SSW_SAFE_RUN, ssw_pkg::SSW_RUN} |-> permit.mbx_allow && permit.pd_allow)
		else $error("run traffic");
	AST_FW_FILE: assert property (state == ssw_pkg::SSW_FW_UPD |-> permit == 3'h2) else $error("fw traffic");
	AST_FW_ENTRY: assert property (state == ssw_pkg::SSW_FW_UPD && $past(state) != ssw_pkg::SSW_FW_UPD
		|-> $past(state) == ssw_pkg::SSW_INIT) else $error("fw entry");
	AST_MBX_CHECK: assert property (req_valid && !copy_req && state == ssw_pkg::SSW_INIT && req_state == ssw_pkg::SSW_CONFIG
		&& !checks.mbx_ok |=> state == ssw_pkg::SSW_INIT && err_flag) else $error("mbx check");
	AST_COPY_FIRST: assert property (s_safe_entry |-> $past(copy_req) && $past(copy_done)) else $error("no copy");
	AST_SAFE_OUT: assert property ((bus_wd_trip || loc_wd_trip) [*2] |-> phys_out == safe_value) else $error("unsafe");
	AST_RUN_OUT: assert property ((state == ssw_pkg::SSW_RUN && !bus_wd_trip && !loc_wd_trip) [*2]
		|-> phys_out == $past(out_data)) else $error("run out");
	AST_BUS_OFF: assert property ((wd_cfg.bus_time == 16'h0000) [*2] |-> !bus_wd_trip) else $error("bus off");
	AST_KICK: assert property (bus_pd_access |=> !bus_wd_trip) else $error("no restart");
	AST_TRIP_STATE: assert property ($rose(bus_wd_trip) && !$past(req_valid) && !$past(copy_req)
		|-> state == $past(state)) else $error("trip moved state");
endmodule
bind ssw_top ssw_top_chk u_ssw_top_chk (.clk, .sys_rst, .wd_cfg, .req_valid, .req_state, .checks, .bus_pd_access,
	.copy_done, .out_data, .safe_value, .state, .permit, .copy_req, .err_flag, .bus_wd_trip, .loc_wd_trip, .phys_out);

// File: ssw_master.sv
// model of the bus master: state requests with its setup results
// assumes requests launch on the falling edge of clk
module ssw_master (
	input  wire logic                   clk,
	output logic                        req_valid,
	output ssw_pkg::ssw_state_type      req_state,
	output ssw_pkg::ssw_check_type      checks,
	output logic [15:0]                 out_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		req_valid = 1'b0;
		req_state = ssw_pkg::SSW_INIT;
		checks    = 3'h0;
		out_data  = 16'h0000;
	end
	// one request pulse; outputs written before it is raised
	task automatic go(input ssw_pkg::ssw_state_type st, input logic [2:0] chk, input logic [15:0] dat);
		@(negedge clk);
		out_data  = dat;
		checks    = chk;
		req_state = st;
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		checks    = ~chk; // results stale once released
	endtask
endmodule

// File: tb_top.sv
// self-checking bench of the state and watchdog block
// assumes the bus master model drives requests and output data
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {ssw_pkg::ssw_state_type st; logic [2:0] chk; ssw_pkg::ssw_state_type exp; logic err; logic [1:0] perm;}
		ssw_row_type;
	logic clk = 1'b0;
	logic sys_rst, req_valid, bus_pd_access, loc_access, copy_done, copy_req, busy, err_flag, bus_wd_trip, loc_wd_trip;
	ssw_pkg::ssw_wd_cfg_type wd_cfg;
	ssw_pkg::ssw_state_type req_state, state;
	ssw_pkg::ssw_check_type checks;
	ssw_pkg::ssw_permit_type permit;
	logic [15:0] out_data, safe_value, phys_out;
	int failures = 0;
	int tests_run = 0;
	int n;
	// request, checks {mbx,pd,dc}, state, error, {mbx,pd} permits
	ssw_row_type rows [10] = '{'{ssw_pkg::SSW_CONFIG, 3'h3, ssw_pkg::SSW_INIT, 1, 2'h0},
		'{ssw_pkg::SSW_RUN, 3'h7, ssw_pkg::SSW_INIT, 1, 2'h0}, '{ssw_pkg::SSW_CONFIG, 3'h4, ssw_pkg::SSW_CONFIG, 0, 2'h2},
		'{ssw_pkg::SSW_FW_UPD, 3'h7, ssw_pkg::SSW_CONFIG, 1, 2'h2}, '{ssw_pkg::SSW_SAFE_RUN, 3'h5, ssw_pkg::SSW_CONFIG, 1, 2'h2},
		'{ssw_pkg::SSW_SAFE_RUN, 3'h6, ssw_pkg::SSW_CONFIG, 1, 2'h2}, '{ssw_pkg::SSW_INIT, 3'h0, ssw_pkg::SSW_INIT, 0, 2'h0},
		'{ssw_pkg::SSW_FW_UPD, 3'h0, ssw_pkg::SSW_FW_UPD, 0, 2'h0}, '{ssw_pkg::SSW_INIT, 3'h0, ssw_pkg::SSW_INIT, 0, 2'h0},
		'{ssw_pkg::SSW_CONFIG, 3'h4, ssw_pkg::SSW_CONFIG, 0, 2'h2}};
	// watchdog rows: multiplier, timer
	logic [31:0] wds [4] = '{32'h0000_0001, 32'h0000_0003, 32'h0002_0002, 32'h0005_0001};
	always #25 clk = ~clk;
	ssw_master u_ssw_master (.clk, .req_valid, .req_state, .checks, .out_data);
	ssw_top u_ssw_top (.clk, .sys_rst, .wd_cfg, .req_valid, .req_state, .checks, .bus_pd_access, .loc_access, .copy_done,
		.out_data, .safe_value, .state, .permit, .copy_req, .busy, .err_flag, .bus_wd_trip, .loc_wd_trip, .phys_out);
	task automatic end_sim();
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// access on both sides restarts both watchdogs
	task automatic kick();
		@(negedge clk);
		bus_pd_access = 1'b1;
		loc_access = 1'b1;
		@(negedge clk);
		bus_pd_access = 1'b0;
		loc_access = 1'b0;
	endtask
	// bounded wait for the bus watchdog, cycles counted
	task automatic wait_trip();
		n = 0;
		while (bus_wd_trip !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		if (n >= 300) begin
			failures++;
			end_sim();
		end
	endtask
	initial begin
		{sys_rst, bus_pd_access, loc_access, copy_done} = 4'h8;
		wd_cfg = 50'h0;
		safe_value = 16'h00A5;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		check("reset state", state, ssw_pkg::SSW_INIT);
		check("reset out", phys_out, 16'h0000);
		foreach (rows[i]) begin
			u_ssw_master.go(rows[i].st, rows[i].chk, 16'h0000);
			check("state", state, rows[i].exp);
			check("error", err_flag, rows[i].err);
			check("permit", {permit.mbx_allow, permit.pd_allow}, rows[i].perm);
		end
		foreach (wds[i]) begin
			wd_cfg = {wds[i][31:16], wds[i][15:0], wds[i][15:0], 2'b11};
			kick();
			wait_trip();
			check("trip time", n >= (wds[i][31:16] + 2) * wds[i][15:0] && n <= (wds[i][31:16] + 2) * wds[i][15:0] + 3, 1);
			check("local trip", loc_wd_trip, 1);
		end
		wd_cfg = {16'h0000, 16'h0010, 16'h0010, 2'b11};
		kick();
		u_ssw_master.go(ssw_pkg::SSW_SAFE_RUN, 3'h7, 16'h1234);
		@(negedge clk);
		check("copy request", copy_req, 1);
		check("busy while copying", busy, 1);
		u_ssw_master.go(ssw_pkg::SSW_RUN, 3'h7, 16'h1234);
		check("held while copying", state, ssw_pkg::SSW_CONFIG);
		copy_done = 1'b1;
		@(negedge clk);
		copy_done = 1'b0;
		@(negedge clk);
		check("safe-run", state, ssw_pkg::SSW_SAFE_RUN);
		check("safe-run out", phys_out, 16'h00A5);
		u_ssw_master.go(ssw_pkg::SSW_RUN, 3'h7, 16'h1234);
		@(negedge clk);
		check("run out", phys_out, 16'h1234);
		wait_trip();
		check("state on trip", state, ssw_pkg::SSW_RUN);
		@(negedge clk);
		check("tripped out", phys_out, 16'h00A5);
		kick();
		check("trip cleared", bus_wd_trip, 0);
		@(negedge clk);
		check("resumed out", phys_out, 16'h1234);
		wd_cfg = {16'h0000, 16'h0000, 16'h0010, 2'b10};
		repeat (60) @(negedge clk);
		check("bus off", bus_wd_trip, 0);
		// no watchdog active: safe-run may drive outputs
		u_ssw_master.go(ssw_pkg::SSW_SAFE_RUN, 3'h7, 16'h5A5A);
		@(negedge clk);
		check("safe-run free state", state, ssw_pkg::SSW_SAFE_RUN);
		check("safe-run free out", phys_out, 16'h5A5A);
		// local watchdog switched on again: outputs back to safe
		wd_cfg = {16'h0000, 16'h0000, 16'h0010, 2'b11};
		@(negedge clk);
		@(negedge clk);
		check("safe-run held out", phys_out, 16'h00A5);
		sys_rst = 1'b1;
		@(negedge clk);
		check("second reset", state, ssw_pkg::SSW_INIT);
		sys_rst = 1'b0;
		end_sim();
	end
endmodule
